// ### logic/ttc_pkg.sv
package ttc_pkg;

	// Register byte addresses, decoded on haddr[7:0].
	localparam logic [7:0] A_PIN_DIR = 8'h00;
	localparam logic [7:0] A_START = 8'h04;
	localparam logic [7:0] A_CH_BASE = 8'h10;
	localparam logic [7:0] OFF_RELOAD = 8'h00;
	localparam logic [7:0] OFF_COUNT = 8'h04;
	localparam logic [7:0] OFF_CTRL = 8'h08;
	localparam logic [7:0] A_CAPTURE = 8'h3C;
	localparam logic [7:0] A_IRQ_STATUS = 8'h40;
	localparam logic [7:0] A_IRQ_MASK = 8'h44;

	// Field positions.
	localparam int PIN_DIR_BIT = 0;
	localparam int UNF_BIT = 8;
	localparam int CAP_FLAG_BIT = 9;
	localparam int CAP_IRQ_BIT = 3;

	// Reset values.
	localparam logic PIN_DIR_RST = 1'h0;
	localparam logic [2:0] START_RST = 3'h0;
	localparam logic [31:0] COUNT_RST = 32'hFFFF_FFFF;
	localparam logic [3:0] IRQ_RST = 4'h0;

	// Prescaler codes.
	localparam logic [2:0] PSC_DIV4 = 3'h0;
	localparam logic [2:0] PSC_DIV16 = 3'h1;
	localparam logic [2:0] PSC_DIV64 = 3'h2;
	localparam logic [2:0] PSC_DIV256 = 3'h3;
	localparam logic [2:0] PSC_RTC = 3'h4;
	localparam logic [2:0] PSC_PIN = 3'h5;

	// Capture control codes.
	localparam logic [1:0] CAP_ON_IRQ = 2'h3;

	// Prescaler divider width; /4, /16, /64 and /256 tap its low 2, 4, 6 and 8 bits.
	localparam int DIV_W = 8;

	typedef struct packed {
		logic [1:0] capture_ctrl;
		logic underflow_irq_enable;
		logic [1:0] edge_select;
		logic [2:0] prescale_sel;
	} ttc_ctrl_s;

	localparam ttc_ctrl_s CTRL_RST = '{2'h0, 1'h0, 2'h0, 3'h0};

endpackage

// ### logic/ttc_top.sv
// How it works
// - The pin direction bit drives the real-time clock out on the timer pin when 1 and makes it an input when 0.
// - Reserved bits of every control register read as zero and software writes zero into them.
// - The pin direction register clears on reset and holds through standby.
// - Start bits 0 to 2 let their channel count when 1 and halt it when 0, halted after reset.
// - The start register clears on reset and, in standby, clears for a non-RTC channel on a PLL change or module stop.
// - Each channel control register clears on reset and holds through standby.
// - The underflow flag sets on counter underflow, clears on a written 0 and ignores a written 1.
// - The channel 2 capture flag sets on a pin capture, clears on a written 0 and ignores a written 1.
// - Capture control 00 is off, 01 reserved, 10 capture without interrupt and 11 capture with interrupt.
// - The underflow interrupt enable lets a set underflow flag raise the channel's underflow request.
// - Edge select 00 is rising, 01 falling and 1x both edges, for counting and capture.
// - Prescale codes select clock /4, /16, /64, /256, the RTC clock or the timer pin; 110 and 111 are reserved.
// - With capture on and the pin as an input, the chosen pin edge copies the channel 2 counter into the capture register.
// - On underflow from zero the counter reloads from its constant and keeps counting down.
`timescale 1ns/1ns
module ttc_top (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic timer_ext_pin_i,
	output logic timer_ext_pin_o,
	output logic timer_ext_pin_oe_n,
	input wire logic rtc_output_clock,
	input wire logic standby,
	input wire logic pll_ratio_change,
	input wire logic module_stop_bit,
	output logic [2:0] underflow_interrupt,
	output logic capture_interrupt,
	output logic irq
);

	logic [7:0] addr_ff;
	logic wr_pend_ff;
	logic rd_pend_ff;
	logic [31:0] hrdata_ff;
	logic hreadyout_ff;
	logic pin_dir_ff;
	logic [2:0] run_ff;
	ttc_pkg::ttc_ctrl_s ctrl_ff [3];
	logic [2:0] unf_ff;
	logic capture_flag_ff;
	logic [31:0] reload_ff [3];
	logic [31:0] count_ff [3];
	logic [31:0] capture_ff;
	logic [3:0] status_ff;
	logic [3:0] mask_ff;
	logic irq_ff;
	logic [2:0] unf_irq_ff;
	logic cap_irq_ff;
	logic pin_o_ff;
	logic pin_oe_n_ff;
	logic [ttc_pkg::DIV_W-1:0] div_ff;
	logic pin_s1_ff;
	logic pin_s2_ff;
	logic pin_prev_ff;
	logic rtc_prev_ff;
	logic accept;
	logic pin_rise;
	logic pin_fall;
	logic rtc_rise;
	logic [3:0] div_tick;
	logic [2:0] tick;
	logic [2:0] uf;
	logic [2:0] wr_ctrl;
	logic [2:0] wr_count;
	logic [2:0] wr_reload;
	logic cap_evt;
	logic [31:0] rd_word;

	function automatic logic [7:0] ch_addr(input logic [1:0] ch, input logic [7:0] off);
		return ttc_pkg::A_CH_BASE + {2'h0, ch, 4'h0} + off;
	endfunction

	function automatic logic edge_hit(input logic [1:0] es, input logic rise, input logic fall);
		return es[1] ? (rise | fall) : (es[0] ? fall : rise);
	endfunction

	assign hrdata = hrdata_ff;
	assign hreadyout = hreadyout_ff;
	assign hresp = 1'b0;
	assign timer_ext_pin_o = pin_o_ff;
	assign timer_ext_pin_oe_n = pin_oe_n_ff;
	assign underflow_interrupt = unf_irq_ff;
	assign capture_interrupt = cap_irq_ff;
	assign irq = irq_ff;

	assign accept = hsel && htrans[1] && hready;

	// Reads take one wait state so that a write just before is always seen.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			addr_ff <= 8'h00;
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			hreadyout_ff <= 1'b1;
		end else if (rd_pend_ff) begin
			rd_pend_ff <= 1'b0;
			hreadyout_ff <= 1'b1;
		end else begin
			wr_pend_ff <= accept && hwrite;
			rd_pend_ff <= accept && !hwrite;
			hreadyout_ff <= !(accept && !hwrite);
			if (accept) begin
				addr_ff <= haddr[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (rd_pend_ff) begin
			hrdata_ff <= rd_word;
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		case (addr_ff)
			ttc_pkg::A_PIN_DIR: rd_word[ttc_pkg::PIN_DIR_BIT] = pin_dir_ff;
			ttc_pkg::A_START: rd_word[2:0] = run_ff;
			ttc_pkg::A_CAPTURE: rd_word = capture_ff;
			ttc_pkg::A_IRQ_STATUS: rd_word[3:0] = status_ff;
			ttc_pkg::A_IRQ_MASK: rd_word[3:0] = mask_ff;
			default: rd_word = 32'h0000_0000;
		endcase
		for (int c = 0; c < 3; c++) begin
			if (addr_ff == ch_addr(2'(c), ttc_pkg::OFF_RELOAD)) begin
				rd_word = reload_ff[c];
			end
			if (addr_ff == ch_addr(2'(c), ttc_pkg::OFF_COUNT)) begin
				rd_word = count_ff[c];
			end
			if (addr_ff == ch_addr(2'(c), ttc_pkg::OFF_CTRL)) begin
				rd_word[7:0] = ctrl_ff[c];
				rd_word[ttc_pkg::UNF_BIT] = unf_ff[c];
				if (c == 2) begin
					rd_word[ttc_pkg::CAP_FLAG_BIT] = capture_flag_ff;
				end
			end
		end
	end

	always_comb begin
		for (int c = 0; c < 3; c++) begin
			wr_ctrl[c] = wr_pend_ff && addr_ff == ch_addr(2'(c), ttc_pkg::OFF_CTRL);
			wr_count[c] = wr_pend_ff && addr_ff == ch_addr(2'(c), ttc_pkg::OFF_COUNT);
			wr_reload[c] = wr_pend_ff && addr_ff == ch_addr(2'(c), ttc_pkg::OFF_RELOAD);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_dir_ff <= ttc_pkg::PIN_DIR_RST;
			pin_o_ff <= 1'b0;
			pin_oe_n_ff <= 1'b1;
		end else begin
			if (wr_pend_ff && addr_ff == ttc_pkg::A_PIN_DIR) begin
				pin_dir_ff <= hwdata[ttc_pkg::PIN_DIR_BIT];
			end
			pin_o_ff <= rtc_output_clock;
			pin_oe_n_ff <= !pin_dir_ff;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_ff <= ttc_pkg::START_RST;
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (standby && (pll_ratio_change || module_stop_bit)
					&& ctrl_ff[c].prescale_sel != ttc_pkg::PSC_RTC) begin
					run_ff[c] <= 1'b0;
				end else if (wr_pend_ff && addr_ff == ttc_pkg::A_START) begin
					run_ff[c] <= hwdata[c];
				end
			end
		end
	end

	// control fields cleared by reset only
	// capture control exists on channel 2 alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 3; c++) begin
				ctrl_ff[c] <= ttc_pkg::CTRL_RST;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (wr_ctrl[c]) begin
					ctrl_ff[c] <= hwdata[7:0];
					if (c != 2) begin
						ctrl_ff[c].capture_ctrl <= 2'h0;
					end
				end
			end
		end
	end

	// two-stage synchroniser, edges seen after it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_ff <= 1'b0;
			pin_s2_ff <= 1'b0;
			pin_prev_ff <= 1'b0;
			rtc_prev_ff <= 1'b0;
			div_ff <= '0;
		end else begin
			pin_s1_ff <= timer_ext_pin_i;
			pin_s2_ff <= pin_s1_ff;
			pin_prev_ff <= pin_s2_ff;
			rtc_prev_ff <= rtc_output_clock;
			div_ff <= div_ff + 1'b1;
		end
	end

	assign pin_rise = pin_s2_ff && !pin_prev_ff;
	assign pin_fall = !pin_s2_ff && pin_prev_ff;
	assign rtc_rise = rtc_output_clock && !rtc_prev_ff;

	always_comb begin
		div_tick[0] = &div_ff[1:0];
		div_tick[1] = &div_ff[3:0];
		div_tick[2] = &div_ff[5:0];
		div_tick[3] = &div_ff[7:0];
	end

	always_comb begin
		for (int c = 0; c < 3; c++) begin
			case (ctrl_ff[c].prescale_sel)
				ttc_pkg::PSC_DIV4: tick[c] = div_tick[0];
				ttc_pkg::PSC_DIV16: tick[c] = div_tick[1];
				ttc_pkg::PSC_DIV64: tick[c] = div_tick[2];
				ttc_pkg::PSC_DIV256: tick[c] = div_tick[3];
				ttc_pkg::PSC_RTC: tick[c] = rtc_rise;
				ttc_pkg::PSC_PIN: tick[c] = edge_hit(ctrl_ff[c].edge_select, pin_rise, pin_fall);
				default: tick[c] = 1'b0;
			endcase
			uf[c] = tick[c] && run_ff[c] && count_ff[c] == 32'h0000_0000 && !wr_count[c];
		end
	end

	// count down and reload on underflow
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int c = 0; c < 3; c++) begin
				count_ff[c] <= ttc_pkg::COUNT_RST;
				reload_ff[c] <= ttc_pkg::COUNT_RST;
			end
		end else begin
			for (int c = 0; c < 3; c++) begin
				if (wr_reload[c]) begin
					reload_ff[c] <= hwdata;
				end
				if (wr_count[c]) begin
					count_ff[c] <= hwdata;
				end else if (uf[c]) begin
					count_ff[c] <= reload_ff[c];
				end else if (tick[c] && run_ff[c]) begin
					count_ff[c] <= count_ff[c] - 32'h0000_0001;
				end
			end
		end
	end

	// capture only with capture on and pin as input
	assign cap_evt = ctrl_ff[2].capture_ctrl[1] && !pin_dir_ff
		&& edge_hit(ctrl_ff[2].edge_select, pin_rise, pin_fall);

	// The capture register has no reset value, so it is left out of reset.
	always_ff @(posedge clk) begin
		if (cap_evt) begin
			capture_ff <= count_ff[2];
		end
	end

	// underflow flag, set wins over a written 0
	// capture flag, set wins over a written 0
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unf_ff <= 3'h0;
			capture_flag_ff <= 1'b0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				unf_ff[c] <= uf[c] || (unf_ff[c] && !(wr_ctrl[c] && !hwdata[ttc_pkg::UNF_BIT]));
			end
			capture_flag_ff <= cap_evt || (capture_flag_ff && !(wr_ctrl[2] && !hwdata[ttc_pkg::CAP_FLAG_BIT]));
		end
	end

	// underflow requests gated by their enable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unf_irq_ff <= 3'h0;
			cap_irq_ff <= 1'b0;
		end else begin
			for (int c = 0; c < 3; c++) begin
				unf_irq_ff[c] <= unf_ff[c] && ctrl_ff[c].underflow_irq_enable;
			end
			cap_irq_ff <= capture_flag_ff && ctrl_ff[2].capture_ctrl == ttc_pkg::CAP_ON_IRQ;
		end
	end

	// Sticky status, write one to clear; a new event in the same cycle stays set.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= ttc_pkg::IRQ_RST;
			mask_ff <= ttc_pkg::IRQ_RST;
			irq_ff <= 1'b0;
		end else begin
			if (wr_pend_ff && addr_ff == ttc_pkg::A_IRQ_STATUS) begin
				status_ff <= (status_ff & ~hwdata[3:0]) | {cap_evt, uf};
			end else begin
				status_ff <= status_ff | {cap_evt, uf};
			end
			if (wr_pend_ff && addr_ff == ttc_pkg::A_IRQ_MASK) begin
				mask_ff <= hwdata[3:0];
			end
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence seq_underflow0;
		uf[0] ##1 unf_ff[0];
	endsequence

	chk_pin_drive_enable: assert property (pin_dir_ff |=> !timer_ext_pin_oe_n)
		else $error("pin not driven in output mode");
	chk_reserved_read_zero: assert property (rd_pend_ff && addr_ff == ttc_pkg::A_START
		|=> hrdata[31:3] == 29'h0)
		else $error("start register reserved bits not zero");
	chk_halt_holds_count: assert property (!run_ff[1] && !wr_count[1] |=> $stable(count_ff[1]))
		else $error("halted counter changed");
	chk_standby_clear_run: assert property (standby && module_stop_bit
		&& ctrl_ff[0].prescale_sel != ttc_pkg::PSC_RTC |=> !run_ff[0])
		else $error("start bit survived module stop");
	chk_underflow_reload: assert property (uf[0] |-> seq_underflow0 ##0 count_ff[0] == $past(reload_ff[0]))
		else $error("no reload or flag on underflow");
	chk_flag_write_one: assert property (unf_ff[2] && wr_ctrl[2] && hwdata[ttc_pkg::UNF_BIT] |=> unf_ff[2])
		else $error("writing one changed underflow flag");
	chk_capture_copy: assert property (cap_evt |=> capture_flag_ff && capture_ff == $past(count_ff[2]))
		else $error("capture did not copy counter");
	chk_capture_off: assert property (!ctrl_ff[2].capture_ctrl[1] && !capture_flag_ff |=> !capture_flag_ff)
		else $error("capture while disabled");
	chk_underflow_request: assert property (unf_ff[1] && ctrl_ff[1].underflow_irq_enable
		|=> underflow_interrupt[1])
		else $error("underflow request missing");
	chk_capture_flag_set: assert property (cap_evt && wr_ctrl[2] |=> capture_flag_ff)
		else $error("capture flag lost to clear");
	chk_sync_delay: assert property (timer_ext_pin_i ##1 timer_ext_pin_i ##1 timer_ext_pin_i |-> pin_s2_ff)
		else $error("pin synchroniser delay wrong");

endmodule // ttc_top

// ### verif/test_three_channel_timer_control.sv
`timescale 1ns/1ns
module test_three_channel_timer_control;
	logic clk, rst_n, hsel, hwrite, pin_i, standby, pll, mstop, hreadyout, hresp, pin_o, pin_oe_n, cap_irq, irq;
	logic rtc = 1'b0;
	logic rtc_d = 1'b0;
	logic [31:0] haddr, hwdata, hrdata, rd, v, ctl;
	logic [1:0] htrans;
	logic [2:0] unf_irq;
	logic hit;
	int miscompares, n_checks;
	int cyc = 0;
	localparam int EXP[8] = '{128, 32, 8, 2, 32, 0, 0, 0};

	ttc_top dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.timer_ext_pin_i(pin_i), .timer_ext_pin_o(pin_o), .timer_ext_pin_oe_n(pin_oe_n), .rtc_output_clock(rtc),
		.standby(standby), .pll_ratio_change(pll), .module_stop_bit(mstop), .underflow_interrupt(unf_irq),
		.capture_interrupt(cap_irq), .irq(irq));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// The real-time clock runs at one sixteenth of the bus clock; a hang ends the run here.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rtc <= cyc[3];
		rtc_d <= rtc;
		if (cyc == 20000) begin
			miscompares++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask

	// Called just after a rising edge; each phase is held until hready is sampled high at a rising edge.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= 32'(a);
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	function automatic logic [7:0] ca(input int c, input logic [7:0] off);
		return ttc_pkg::A_CH_BASE + 8'(16 * c) + off;
	endfunction

	function automatic logic [31:0] ctrl_exp(input int c, input logic [31:0] w);
		return (c == 2) ? {24'h0, w[7:0]} : {26'h0, w[5:0]};
	endfunction

	function automatic logic cnt_ok(input logic [31:0] d, input int e);
		return (e == 0) ? (d == 0) : (d >= 32'(e - 1) && d <= 32'(e + 2));
	endfunction

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		pin_i = 1'b0;
		standby = 1'b0;
		pll = 1'b0;
		mstop = 1'b0;
		miscompares = 0;
		n_checks = 0;
		v = $urandom(32'h4453);
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 3; c++) begin
			rdc(ca(c, ttc_pkg::OFF_CTRL), 32'h0);
			rdc(ca(c, ttc_pkg::OFF_COUNT), 32'hFFFF_FFFF);
			bus(1'b1, ca(c, ttc_pkg::OFF_CTRL), 32'hFFFF_FFFF);
			rdc(ca(c, ttc_pkg::OFF_CTRL), ctrl_exp(c, 32'hFFFF_FFFF));
		end
		rdc(ttc_pkg::A_PIN_DIR, 32'h0);
		rdc(ttc_pkg::A_START, 32'h0);
		rdc(ttc_pkg::A_IRQ_STATUS, 32'h0);
		rdc(8'h80, 32'h0);
		bus(1'b1, ttc_pkg::A_START, 32'hFFFF_FFFF);
		rdc(ttc_pkg::A_START, 32'h7);
		bus(1'b1, ttc_pkg::A_START, 32'h0);
		bus(1'b1, ttc_pkg::A_PIN_DIR, 32'hFFFF_FFFF);
		rdc(ttc_pkg::A_PIN_DIR, 32'h1);
		chk(32'(pin_oe_n), 32'h0);
		repeat (40) begin
			@(negedge clk);
			chk(32'(pin_o), 32'(rtc_d));
		end
		@(posedge clk);
		repeat (6) begin
			v = $urandom;
			bus(1'b1, ca(int'($urandom_range(2)), ttc_pkg::OFF_RELOAD), v);
			chk(32'(hresp), 32'h0);
			rdc(8'(haddr), v);
		end
		for (int p = 0; p < 8; p++) begin
			if (p != 5) begin
				bus(1'b1, ca(1, ttc_pkg::OFF_CTRL), 32'(p));
				bus(1'b1, ca(1, ttc_pkg::OFF_COUNT), 32'h1000_0000);
				bus(1'b1, ttc_pkg::A_START, 32'h2);
				repeat (512) @(posedge clk);
				bus(1'b0, ca(1, ttc_pkg::OFF_COUNT), 32'h0);
				bus(1'b1, ttc_pkg::A_START, 32'h0);
				chk(32'(cnt_ok(32'h1000_0000 - rd, EXP[p])), 32'h1);
			end
		end
		bus(1'b1, ca(1, ttc_pkg::OFF_CTRL), 32'h0);
		bus(1'b0, ca(1, ttc_pkg::OFF_COUNT), 32'h0);
		v = rd;
		repeat (20) @(posedge clk);
		rdc(ca(1, ttc_pkg::OFF_COUNT), v);
		bus(1'b1, ca(0, ttc_pkg::OFF_RELOAD), 32'h0000_1000);
		bus(1'b1, ca(0, ttc_pkg::OFF_CTRL), 32'h0);
		bus(1'b1, ca(0, ttc_pkg::OFF_COUNT), 32'h2);
		bus(1'b1, ttc_pkg::A_START, 32'h1);
		repeat (60) @(posedge clk);
		bus(1'b1, ttc_pkg::A_START, 32'h0);
		bus(1'b0, ca(0, ttc_pkg::OFF_COUNT), 32'h0);
		chk(32'(rd <= 32'h0000_1000 && rd >= 32'h0000_0FEC), 32'h1);
		rdc(ca(0, ttc_pkg::OFF_CTRL), 32'h100);
		chk(32'(unf_irq), 32'h0);
		bus(1'b1, ca(0, ttc_pkg::OFF_CTRL), 32'h120);
		rdc(ca(0, ttc_pkg::OFF_CTRL), 32'h120);
		chk(32'(unf_irq), 32'h1);
		rdc(ttc_pkg::A_IRQ_STATUS, 32'h1);
		chk(32'(irq), 32'h0);
		bus(1'b1, ttc_pkg::A_IRQ_MASK, 32'h1);
		rdc(ttc_pkg::A_IRQ_MASK, 32'h1);
		chk(32'(irq), 32'h1);
		bus(1'b1, ttc_pkg::A_IRQ_STATUS, 32'h1);
		rdc(ttc_pkg::A_IRQ_STATUS, 32'h0);
		chk(32'(irq), 32'h0);
		bus(1'b1, ca(0, ttc_pkg::OFF_CTRL), 32'h20);
		rdc(ca(0, ttc_pkg::OFF_CTRL), 32'h20);
		chk(32'(unf_irq), 32'h0);
		// Capture needs the pin as an input; step 0 uses code 10, step 4 the reserved code 01.
		bus(1'b1, ttc_pkg::A_PIN_DIR, 32'h0);
		for (int i = 0; i < 5; i++) begin
			ctl = {24'h0, (i == 0) ? 2'h2 : ((i == 4) ? 2'h1 : 2'h3), 1'b0, 2'(i), 3'h0};
			v = $urandom;
			bus(1'b1, ca(2, ttc_pkg::OFF_COUNT), v);
			bus(1'b1, ca(2, ttc_pkg::OFF_CTRL), ctl);
			for (int f = 0; f < 2; f++) begin
				@(posedge clk);
				pin_i <= ~pin_i;
				repeat (6) @(posedge clk);
				hit = ctl[7] && ((f == 0) ? (ctl[4:3] != 2'h1) : (ctl[4:3] != 2'h0));
				rdc(ca(2, ttc_pkg::OFF_CTRL), ctl | {22'h0, hit, 9'h0});
				chk(32'(cap_irq), 32'(hit && ctl[6]));
				if (hit) begin
					rdc(ttc_pkg::A_CAPTURE, v);
				end
				bus(1'b1, ca(2, ttc_pkg::OFF_CTRL), ctl);
			end
		end
		rdc(ttc_pkg::A_IRQ_STATUS, 32'h8);
		bus(1'b1, ttc_pkg::A_PIN_DIR, 32'h1);
		bus(1'b1, ca(1, ttc_pkg::OFF_CTRL), 32'h4);
		for (int k = 0; k < 2; k++) begin
			bus(1'b1, ttc_pkg::A_START, 32'h7);
			@(posedge clk);
			standby <= 1'b1;
			pll <= (k == 0);
			mstop <= (k == 1);
			repeat (4) @(posedge clk);
			standby <= 1'b0;
			pll <= 1'b0;
			mstop <= 1'b0;
			rdc(ttc_pkg::A_START, 32'h2);
			rdc(ttc_pkg::A_PIN_DIR, 32'h1);
			rdc(ca(1, ttc_pkg::OFF_CTRL), 32'h4);
		end
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdc(ttc_pkg::A_PIN_DIR, 32'h0);
		rdc(ttc_pkg::A_START, 32'h0);
		rdc(ca(1, ttc_pkg::OFF_CTRL), 32'h0);
		chk(32'(pin_oe_n), 32'h1);
		complete_run();
	end
endmodule // test_three_channel_timer_control
